// file: pkg/region_attr_pkg.sv
// Purpose: Shared constants and types for the region attribute lookup.
// Assumes: Register offsets are byte addresses in control register space.
// Notes:   Region configuration words sit in a block of eight aligned words.
package region_attr_pkg;

    // Register offsets
    localparam logic [15:0] BUS_CONTROL_OFS             = 16'h86FC;
    localparam logic [15:0] DEFAULT_TEMPLATE_CONFIG_OFS = 16'h8100;
    localparam logic [15:0] TEMPLATE0_BASE_OFS          = 16'h8108;
    localparam logic [15:0] TEMPLATE0_MASK_OFS          = 16'h810C;
    localparam logic [15:0] TEMPLATE1_BASE_OFS          = 16'h8110;
    localparam logic [15:0] TEMPLATE1_MASK_OFS          = 16'h8114;
    localparam logic [15:0] REGION_CONFIG_OFS           = 16'h8600;

    // Region table geometry
    localparam int NUM_REGIONS  = 8;
    localparam int NUM_RD_PORTS = 4;
    localparam int REGION_MSB   = 31;
    localparam int REGION_LSB   = 29;
    localparam logic [2:0] TOP_REGION_IDX = 3'h7;

    // Field positions
    localparam int WIDTH_MSB           = 23;
    localparam int WIDTH_LSB           = 22;
    localparam int BCTL_VALID_BIT      = 0;
    localparam int BCTL_USER_PROT_BIT  = 1;
    localparam int BCTL_SUP_PROT_BIT   = 2;
    localparam int TEMPLATE_ADDR_MSB   = 31;
    localparam int TEMPLATE_ADDR_LSB   = 12;
    localparam int TEMPLATE_CACHE_BIT  = 1;
    localparam int TEMPLATE_ENABLE_BIT = 0;
    localparam int DEFAULT_CACHE_BIT   = 1;

    // Reset values
    localparam logic [2:0]  BUS_CONTROL_RST     = 3'h0;
    localparam logic [31:0] REGION_CONFIG_RST   = 32'h0;
    localparam logic        TEMPLATE_ENABLE_RST = 1'b0;
    localparam logic        DEFAULT_CACHE_RST   = 1'b0;

    // Supervisor-protected span at the bottom of internal data RAM
    localparam logic [31:0] SUP_PROT_BYTES = 32'h40;

    typedef enum logic [1:0] {
        WIDTH_8    = 2'b00,
        WIDTH_16   = 2'b01,
        WIDTH_32   = 2'b10,
        WIDTH_RSVD = 2'b11
    } width_type;

    typedef enum logic [1:0] {
        BOOT_REGIONS     = 2'b00,
        BOOT_BUS_CONTROL = 2'b01,
        BOOT_DONE        = 2'b10
    } boot_type;

endpackage

// file: rtl/region_table_mem.sv
// Purpose: Eight-word region configuration store with registered read ports.
// Assumes: One write per cycle; each read port returns data one edge later.
// Notes:   Reset clears every cell so the top region starts at 8-bit width.
module region_table_mem
    import region_attr_pkg::*;
(
    input  wire logic                                i_clk,
    input  wire logic                                i_rst,
    input  wire logic                                i_we,
    input  wire logic [2:0]                          i_widx,
    input  wire logic [31:0]                         i_wdata,
    input  wire logic [NUM_RD_PORTS-1:0][2:0]        i_raddr,
    output logic      [NUM_RD_PORTS-1:0][31:0]       o_rdata
);

    typedef struct packed {
        logic [NUM_REGIONS-1:0][31:0]  cells;
        logic [NUM_RD_PORTS-1:0][31:0] rdata;
    } mem_state_type;

    mem_state_type s;
    mem_state_type next_s;

    // Read first, reads see the old word in the same cycle
    always_comb begin
        next_s = s;
        if (i_we) begin
            next_s.cells[i_widx] = i_wdata;
        end
        for (int p = 0; p < NUM_RD_PORTS; p++) begin
            next_s.rdata[p] = s.cells[i_raddr[p]];
        end
        if (i_rst) begin
            next_s.cells = '0;
            next_s.rdata = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        s <= next_s;
    end

    assign o_rdata = s.rdata;

endmodule

// file: rtl/template_match.sv
// Purpose: Address compare of one logical template against an access.
// Assumes: Only address bits 31:12 take part in the compare.
// Notes:   Purely combinational; the caller registers the outcome.
module template_match (
    input  wire logic        i_enable,
    input  wire logic [19:0] i_addr,
    input  wire logic [19:0] i_base,
    input  wire logic [19:0] i_mask,
    output logic             o_match
);

    // Masked bits (mask 0) always agree, so a zero mask matches everything
    assign o_match = i_enable & (&((i_addr ~^ i_base) | ~i_mask));

endmodule

// file: rtl/region_attr_lookup.sv
// Purpose: Per-access bus width and cacheability lookup for the bus controller.
// Assumes: Access inputs are synchronous; length is 1 to 16 bytes; data RAM starts at 0.
// Notes:   Answer registered two edges after a request, from current contents.
//
// Notes on behaviour
// - All eight region registers are loaded from the boot control table automatically.
// - After reset the table is invalid and the top region applies everywhere.
// - Reset clears the top region register, giving 8-bit width to every external access; internal paths stay 32-bit.
// - Boot loads region registers first, then the bus control register.
// - Table-valid bit 0 selects per-region settings; clear means top region.
// - Bus control bit 2 blocks supervisor writes to first 64 RAM bytes.
// - Bus control bit 1 blocks user-mode writes to internal data RAM.
// - Internal memory and core registers use 32-bit paths; register cache 128-bit.
// - External access crossing a region boundary is split; each piece uses its region.
// - Region register update waits until the access in progress finishes.
// - Template base holds address bits 31:12; low twelve bits are zero.
// - Template base bit 1 enables data caching for matching accesses.
// - Template mask bits 31:12 choose which address bits are compared.
// - Accesses matching no template take cacheability from the default register.
// - Default register bit 1 enables write-through caching for unmatched areas.
// - Width field bits 23:22: 00 8-bit, 01 16-bit, 10 32-bit.
// - Template matches when all unmasked bits 31:12 equal the base.
// - Mask bit 0 activates a template; reset clears it.
module region_attr_lookup
    import region_attr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_boot_valid,
    input  wire logic [31:0] i_boot_data,
    output logic             o_boot_ready,
    output logic             o_boot_done,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    output logic [31:0]      o_reg_rdata,
    output logic             o_reg_rvalid,
    input  wire logic        i_acc_req,
    input  wire logic [31:0] i_acc_addr,
    input  wire logic [4:0]  i_acc_len,
    input  wire logic        i_acc_write,
    input  wire logic        i_acc_user,
    input  wire logic        i_acc_internal,
    input  wire logic        i_acc_dram,
    input  wire logic        i_acc_lrc,
    input  wire logic        i_acc_busy,
    output logic             o_acc_valid,
    output logic [1:0]       o_bus_width,
    output logic             o_split,
    output logic [31:0]      o_split_addr,
    output logic [1:0]       o_split_width,
    output logic             o_path_internal,
    output logic             o_path_128,
    output logic             o_cacheable,
    output logic             o_write_through,
    output logic             o_write_block
);

    typedef struct packed {
        boot_type    boot;
        logic [2:0]  boot_cnt;
        logic        boot_ready;
        logic        boot_done;
        logic [2:0]  bus_control;
        logic        dflt_cache;
        logic [1:0][19:0] t_base;
        logic [1:0]  t_cache;
        logic [1:0][19:0] t_mask;
        logic [1:0]  t_enable;
        logic        pend_valid;
        logic [2:0]  pend_idx;
        logic [31:0] pend_data;
        logic        s1_acc;
        logic [31:0] s1_addr;
        logic        s1_split;
        logic [2:0]  s1_end_region;
        logic        s1_write;
        logic        s1_user;
        logic        s1_internal;
        logic        s1_dram;
        logic        s1_lrc;
        logic        s1_rd;
        logic [15:0] s1_rd_addr;
        logic        acc_valid;
        width_type   bus_width;
        logic        split;
        logic [31:0] split_addr;
        width_type   split_width;
        logic        path_internal;
        logic        path_128;
        logic        cacheable;
        logic        write_through;
        logic        write_block;
        logic [31:0] reg_rdata;
        logic        reg_rvalid;
    } state_type;

    state_type s;
    state_type next_s;

    // Region register window decode, used by the write and read paths
    function automatic logic is_region_reg(input logic [15:0] a);
        return a[15:5] == REGION_CONFIG_OFS[15:5];
    endfunction

    function automatic width_type width_of(input logic [31:0] cfg);
        return width_type'(cfg[WIDTH_MSB:WIDTH_LSB]);
    endfunction

    logic                          mem_we;
    logic [2:0]                    mem_widx;
    logic [31:0]                   mem_wdata;
    logic [NUM_RD_PORTS-1:0][2:0]  mem_raddr;
    logic [NUM_RD_PORTS-1:0][31:0] mem_rdata;
    logic [1:0]                    t_hit;
    logic [31:0]                   acc_end;

    // Last byte of the access decides whether it crosses into the next region
    assign acc_end = i_acc_addr + 32'(i_acc_len) - 32'h1;

    // Ports: first region, last-byte region, register read, top region
    assign mem_raddr[0] = i_acc_addr[REGION_MSB:REGION_LSB];
    assign mem_raddr[1] = acc_end[REGION_MSB:REGION_LSB];
    assign mem_raddr[2] = i_reg_addr[4:2];
    assign mem_raddr[3] = TOP_REGION_IDX;

    region_table_mem u_table (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_we    (mem_we),
        .i_widx  (mem_widx),
        .i_wdata (mem_wdata),
        .i_raddr (mem_raddr),
        .o_rdata (mem_rdata)
    );

    // One comparator per logical template on the latched access address
    for (genvar t = 0; t < 2; t++) begin : g_tmpl
        template_match u_match (
            .i_enable (s.t_enable[t]),
            .i_addr   (s.s1_addr[TEMPLATE_ADDR_MSB:TEMPLATE_ADDR_LSB]),
            .i_base   (s.t_base[t]),
            .i_mask   (s.t_mask[t]),
            .o_match  (t_hit[t])
        );
    end

    // Table write port: boot load has priority over a deferred register write
    always_comb begin
        mem_we    = 1'b0;
        mem_widx  = s.pend_idx;
        mem_wdata = s.pend_data;
        if (s.boot == BOOT_REGIONS && i_boot_valid && s.boot_ready) begin
            mem_we    = 1'b1;
            mem_widx  = s.boot_cnt;
            mem_wdata = i_boot_data;
        end else if (s.pend_valid && !i_acc_busy) begin
            mem_we    = 1'b1;
        end
    end

    // Next-state logic for boot, registers, pending update and lookup
    always_comb begin
        logic [31:0] first_cfg;
        logic [31:0] end_cfg;
        logic        internal;
        logic        no_hit;
        first_cfg = '0;
        end_cfg   = '0;
        internal  = 1'b0;
        no_hit    = 1'b0;
        next_s    = s;

        // Boot sequence: eight region words, then the bus control word
        case (s.boot)
            BOOT_REGIONS: begin
                if (i_boot_valid && s.boot_ready) begin
                    next_s.boot_cnt = s.boot_cnt + 3'h1;
                    if (s.boot_cnt == TOP_REGION_IDX) begin
                        next_s.boot = BOOT_BUS_CONTROL;
                    end
                end
            end
            BOOT_BUS_CONTROL: begin
                if (i_boot_valid && s.boot_ready) begin
                    next_s.bus_control = i_boot_data[2:0];
                    next_s.boot        = BOOT_DONE;
                    next_s.boot_ready  = 1'b0;
                    next_s.boot_done   = 1'b1;
                end
            end
            BOOT_DONE: begin
                next_s.boot_ready = 1'b0;
            end
            default: begin
                next_s.boot = BOOT_DONE;
            end
        endcase

        // Deferred region update retires on the edge that writes it; boot words come first
        if (s.pend_valid && !i_acc_busy &&
            !(s.boot == BOOT_REGIONS && i_boot_valid && s.boot_ready)) begin
            next_s.pend_valid = 1'b0;
        end

        // Register writes; region words are parked until the bus is idle
        if (i_reg_wr) begin
            if (is_region_reg(i_reg_addr)) begin
                next_s.pend_valid = 1'b1;
                next_s.pend_idx   = i_reg_addr[4:2];
                next_s.pend_data  = i_reg_wdata;
            end
            case (i_reg_addr)
                BUS_CONTROL_OFS: begin
                    next_s.bus_control = i_reg_wdata[2:0];
                end
                DEFAULT_TEMPLATE_CONFIG_OFS: begin
                    next_s.dflt_cache = i_reg_wdata[DEFAULT_CACHE_BIT];
                end
                TEMPLATE0_BASE_OFS: begin
                    next_s.t_base[0]  = i_reg_wdata[TEMPLATE_ADDR_MSB:TEMPLATE_ADDR_LSB];
                    next_s.t_cache[0] = i_reg_wdata[TEMPLATE_CACHE_BIT];
                end
                TEMPLATE0_MASK_OFS: begin
                    next_s.t_mask[0]   = i_reg_wdata[TEMPLATE_ADDR_MSB:TEMPLATE_ADDR_LSB];
                    next_s.t_enable[0] = i_reg_wdata[TEMPLATE_ENABLE_BIT];
                end
                TEMPLATE1_BASE_OFS: begin
                    next_s.t_base[1]  = i_reg_wdata[TEMPLATE_ADDR_MSB:TEMPLATE_ADDR_LSB];
                    next_s.t_cache[1] = i_reg_wdata[TEMPLATE_CACHE_BIT];
                end
                TEMPLATE1_MASK_OFS: begin
                    next_s.t_mask[1]   = i_reg_wdata[TEMPLATE_ADDR_MSB:TEMPLATE_ADDR_LSB];
                    next_s.t_enable[1] = i_reg_wdata[TEMPLATE_ENABLE_BIT];
                end
                default: begin
                end
            endcase
        end

        // Stage 1: latch the request while the table words are read
        next_s.s1_acc        = i_acc_req;
        next_s.s1_addr       = i_acc_addr;
        next_s.s1_split      = acc_end[REGION_MSB:REGION_LSB] != i_acc_addr[REGION_MSB:REGION_LSB];
        next_s.s1_end_region = acc_end[REGION_MSB:REGION_LSB];
        next_s.s1_write      = i_acc_write;
        next_s.s1_user       = i_acc_user;
        next_s.s1_internal   = i_acc_internal;
        next_s.s1_dram       = i_acc_dram;
        next_s.s1_lrc        = i_acc_lrc;
        next_s.s1_rd         = i_reg_rd;
        next_s.s1_rd_addr    = i_reg_addr;

        // Stage 2: pick the region source, then the width of each piece
        if (s.bus_control[BCTL_VALID_BIT]) begin
            first_cfg = mem_rdata[0];
            end_cfg   = mem_rdata[1];
        end else begin
            first_cfg = mem_rdata[3];
            end_cfg   = mem_rdata[3];
        end
        internal = s.s1_internal | s.s1_dram | s.s1_lrc;
        no_hit   = ~|t_hit;
        next_s.acc_valid     = s.s1_acc;
        next_s.path_internal = internal;
        next_s.path_128      = s.s1_lrc;
        next_s.bus_width     = internal ? WIDTH_32 : width_of(first_cfg);
        next_s.split         = s.s1_split && !internal;
        next_s.split_addr    = {s.s1_end_region, 29'h0};
        next_s.split_width   = width_of(end_cfg);
        // Internal RAM is never cached; overlapping templates favour template 0
        if (internal) begin
            next_s.cacheable = 1'b0;
        end else if (t_hit[0]) begin
            next_s.cacheable = s.t_cache[0];
        end else if (t_hit[1]) begin
            next_s.cacheable = s.t_cache[1];
        end else begin
            next_s.cacheable = s.dflt_cache;
        end
        next_s.write_through = !internal && no_hit && s.dflt_cache;
        next_s.write_block   = s.s1_write && s.s1_dram &&
            ((s.s1_user && s.bus_control[BCTL_USER_PROT_BIT]) ||
             (!s.s1_user && s.bus_control[BCTL_SUP_PROT_BIT] &&
              s.s1_addr < SUP_PROT_BYTES));

        // Register read answer; unmapped offsets read as zero
        next_s.reg_rvalid = s.s1_rd;
        next_s.reg_rdata  = '0;
        if (is_region_reg(s.s1_rd_addr)) begin
            next_s.reg_rdata = mem_rdata[2];
        end else begin
            case (s.s1_rd_addr)
                BUS_CONTROL_OFS:             next_s.reg_rdata = {29'h0, s.bus_control};
                DEFAULT_TEMPLATE_CONFIG_OFS: next_s.reg_rdata = {30'h0, s.dflt_cache, 1'b0};
                TEMPLATE0_BASE_OFS: next_s.reg_rdata = {s.t_base[0], 10'h0, s.t_cache[0], 1'b0};
                TEMPLATE0_MASK_OFS: next_s.reg_rdata = {s.t_mask[0], 11'h0, s.t_enable[0]};
                TEMPLATE1_BASE_OFS: next_s.reg_rdata = {s.t_base[1], 10'h0, s.t_cache[1], 1'b0};
                TEMPLATE1_MASK_OFS: next_s.reg_rdata = {s.t_mask[1], 11'h0, s.t_enable[1]};
                default:            next_s.reg_rdata = '0;
            endcase
        end

        // Synchronous reset; the top region word is cleared in the table
        if (i_rst) begin
            next_s             = '0;
            next_s.boot        = BOOT_REGIONS;
            next_s.boot_ready  = 1'b1;
            next_s.bus_control = BUS_CONTROL_RST;
            next_s.t_enable    = {2{TEMPLATE_ENABLE_RST}};
            next_s.dflt_cache  = DEFAULT_CACHE_RST;
            next_s.bus_width   = WIDTH_8;
            next_s.split_width = WIDTH_8;
        end
    end

    always_ff @(posedge i_clk) begin
        s <= next_s;
    end

    // Every output is a state flop
    assign o_boot_ready    = s.boot_ready;
    assign o_boot_done     = s.boot_done;
    assign o_reg_rdata     = s.reg_rdata;
    assign o_reg_rvalid    = s.reg_rvalid;
    assign o_acc_valid     = s.acc_valid;
    assign o_bus_width     = s.bus_width;
    assign o_split         = s.split;
    assign o_split_addr    = s.split_addr;
    assign o_split_width   = s.split_width;
    assign o_path_internal = s.path_internal;
    assign o_path_128      = s.path_128;
    assign o_cacheable     = s.cacheable;
    assign o_write_through = s.write_through;
    assign o_write_block   = s.write_block;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    a_top_cleared: assert property ($fell(i_rst) |=> mem_rdata[3] == REGION_CONFIG_RST)
        else $error("top region not cleared by reset");
    a_reset_invalid: assert property ($past(i_rst) |-> s.bus_control == BUS_CONTROL_RST
        && s.t_enable == 2'b00) else $error("table valid or template active after reset");
    a_invalid_top: assert property (o_acc_valid && !o_path_internal
        && !$past(s.bus_control[BCTL_VALID_BIT])
        |-> o_bus_width == width_of($past(mem_rdata[3])))
        else $error("invalid table did not use top region width");
    a_internal_path: assert property ((i_acc_req && (i_acc_internal || i_acc_dram))
        |-> ##2 o_acc_valid && o_bus_width == WIDTH_32 && o_path_internal && !o_cacheable)
        else $error("internal access not given 32-bit path");
    a_boot_order: assert property (s.boot == BOOT_BUS_CONTROL && $past(s.boot) == BOOT_REGIONS
        |-> $past(s.boot_cnt) == TOP_REGION_IDX)
        else $error("bus control loaded before all region words");
    a_sup_protect: assert property ((i_acc_req && i_acc_write && i_acc_dram && !i_acc_user
        && i_acc_addr < SUP_PROT_BYTES) ##1 s.bus_control[BCTL_SUP_PROT_BIT]
        |=> o_write_block) else $error("supervisor write to protected RAM not blocked");
    a_user_protect: assert property ((i_acc_req && i_acc_write && i_acc_dram && i_acc_user)
        ##1 !s.bus_control[BCTL_USER_PROT_BIT] |=> !o_write_block)
        else $error("user write blocked while protection is off");
    a_defer_update: assert property (s.pend_valid && i_acc_busy |-> !mem_we
        || s.boot == BOOT_REGIONS) else $error("region update applied during busy access");
    a_split_mark: assert property (i_acc_req && !i_acc_internal && !i_acc_dram && !i_acc_lrc
        && acc_end[31:29] != i_acc_addr[31:29] |-> ##2 o_split)
        else $error("region-crossing access not split");
    a_answer_time: assert property (i_acc_req |-> ##2 o_acc_valid)
        else $error("lookup answer not two cycles after request");

endmodule

// file: sim/boot_table_source.sv
// Purpose: Boot table source, eight region words then the bus control word.
// Assumes: A word is taken at a rising edge with valid and ready both high.
// Notes:   While idle the data lines show the inverse of the last word.
module boot_table_source (
    input  wire logic        i_clk,
    input  wire logic        i_start,
    input  wire logic        i_ready,
    output logic             o_valid,
    output logic [31:0]      o_data
);
    timeunit 1ns;
    timeprecision 100ps;
    int idx = 0;
    initial o_valid = 1'b0;
    initial o_data = 32'h0;
    // Count the words the device has taken
    always @(posedge i_clk) if (o_valid && i_ready) idx <= idx + 1;
    // Region n asks for width n mod 3; last word sets only the valid bit
    always @(negedge i_clk) begin
        o_valid <= i_start && idx < 9;
        if (i_start && idx < 9) o_data <= (idx < 8) ? 32'(idx % 3) << 22 : 32'h1;
        else if (o_valid) o_data <= ~o_data;
    end
endmodule

// file: sim/test_region_attr_lookup.sv
// Purpose: Self-checking bench for the region attribute lookup.
// Assumes: Boot words come from boot_table_source once go rises.
// Notes:   Inputs change on falling edges; answers are read at the falling edge after they rise.
module test_region_attr_lookup;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk, i_rst, go, i_boot_valid, o_boot_ready, o_boot_done, i_reg_wr;
    logic        i_reg_rd, i_acc_req, i_acc_write, i_acc_user, i_acc_internal, i_acc_dram;
    logic        i_acc_lrc, i_acc_busy, o_reg_rvalid, o_acc_valid, o_split, o_path_internal;
    logic        o_path_128, o_cacheable, o_write_through, o_write_block;
    logic [1:0]  o_bus_width, o_split_width;
    logic [4:0]  i_acc_len;
    logic [15:0] i_reg_addr;
    logic [31:0] i_boot_data, i_reg_wdata, o_reg_rdata, i_acc_addr, o_split_addr;
    int          miscompares = 0, n_compared = 0, cycles = 0;
    region_attr_lookup dut (.i_clk, .i_rst, .i_boot_valid, .i_boot_data, .o_boot_ready,
        .o_boot_done, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
        .o_reg_rvalid, .i_acc_req, .i_acc_addr, .i_acc_len, .i_acc_write, .i_acc_user,
        .i_acc_internal, .i_acc_dram, .i_acc_lrc, .i_acc_busy, .o_acc_valid, .o_bus_width,
        .o_split, .o_split_addr, .o_split_width, .o_path_internal, .o_path_128,
        .o_cacheable, .o_write_through, .o_write_block);
    boot_table_source src (.i_clk, .i_start(go), .i_ready(o_boot_ready),
        .o_valid(i_boot_valid), .o_data(i_boot_data));
    // Clock at 250 MHz
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // Cut a hang short
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Extra edge at the end so back-to-back writes always retoggle the strobe
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
        @(negedge i_clk);
        i_reg_wr = 1'b0;
        @(negedge i_clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        {i_reg_rd, i_reg_addr} = {1'b1, a};
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        @(negedge i_clk);
        chk(o_reg_rvalid, 32'h1);
        chk(o_reg_rdata, exp);
    endtask
    // Flags: write, user, internal, data RAM, register cache
    task automatic look(input logic [31:0] a, input logic [4:0] n, input logic [4:0] f);
        {i_acc_addr, i_acc_len, i_acc_req} = {a, n, 1'b1};
        {i_acc_write, i_acc_user, i_acc_internal, i_acc_dram, i_acc_lrc} = f;
        @(negedge i_clk);
        i_acc_req = 1'b0;
        @(negedge i_clk);
        chk(o_acc_valid, 32'h1);
    endtask
    task automatic t_reset();
        rd(16'h86FC, 32'h0);
        rd(16'h7000, 32'h0);
        chk(o_boot_ready, 32'h1);
        look(32'hE000_0000, 5'h04, 5'h00);
        chk(o_bus_width, 32'h0);
        look(32'h2000_0000, 5'h04, 5'h00);
        chk(o_bus_width, 32'h0);
    endtask
    task automatic t_boot();
        go = 1'b1;
        for (int i = 0; i < 20 && o_boot_done !== 1'b1; i++) @(negedge i_clk);
        chk({o_boot_done, o_boot_ready}, 32'h2);
        rd(16'h861C, 32'h0040_0000);
        for (int n = 0; n < 8; n++) begin
            look(n << 29, 5'h04, 5'h00);
            chk(o_bus_width, n % 3);
        end
    endtask
    task automatic t_path_split();
        look(32'h0, 5'h04, 5'h04);
        chk({o_path_internal, o_bus_width}, 32'h6);
        look(32'h0, 5'h10, 5'h01);
        chk(o_path_128, 32'h1);
        look(32'h1FFF_FFFE, 5'h10, 5'h00);
        chk({o_split, o_bus_width, o_split_width}, 32'h11);
        chk(o_split_addr, 32'h2000_0000);
    endtask
    task automatic t_protect();
        wr(16'h86FC, 32'h7);
        look(32'h100, 5'h04, 5'h1A);
        chk(o_write_block, 32'h1);
        look(32'h3C, 5'h04, 5'h12);
        chk(o_write_block, 32'h1);
        look(32'h40, 5'h04, 5'h12);
        chk(o_write_block, 32'h0);
        wr(16'h86FC, 32'h1);
        look(32'h100, 5'h04, 5'h1A);
        chk(o_write_block, 32'h0);
    endtask
    task automatic t_template();
        wr(16'h8108, 32'h0010_0002);
        wr(16'h810C, 32'hFFFF_0000);
        look(32'h0010_8000, 5'h04, 5'h00);
        chk(o_cacheable, 32'h0);
        wr(16'h810C, 32'hFFFF_0001);
        look(32'h0010_FFFC, 5'h04, 5'h00);
        chk(o_cacheable, 32'h1);
        look(32'h0011_0000, 5'h04, 5'h00);
        chk({o_cacheable, o_write_through}, 32'h0);
        wr(16'h8100, 32'h2);
        look(32'h0011_0000, 5'h04, 5'h00);
        chk(o_write_through, 32'h1);
        wr(16'h8110, 32'h0020_0002);
        wr(16'h8114, 32'hFFFF_0001);
        rd(16'h8114, 32'hFFFF_0001);
        look(32'h0020_0000, 5'h04, 5'h00);
        chk({o_cacheable, o_write_through}, 32'h2);
    endtask
    // Region update parked while an access is in progress
    task automatic t_defer();
        i_acc_busy = 1'b1;
        wr(16'h8600, 32'h0040_0000);
        look(32'h0, 5'h04, 5'h00);
        chk(o_bus_width, 32'h0);
        i_acc_busy = 1'b0;
        repeat (3) @(negedge i_clk);
        rd(16'h8600, 32'h0040_0000);
        look(32'h0, 5'h04, 5'h00);
        chk(o_bus_width, 32'h1);
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {i_rst, go, i_reg_wr, i_reg_rd, i_acc_req, i_acc_busy} = 6'h20;
        {i_reg_addr, i_reg_wdata, i_acc_addr, i_acc_len} = 85'h0;
        {i_acc_write, i_acc_user, i_acc_internal, i_acc_dram, i_acc_lrc} = 5'h00;
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        t_reset();
        t_boot();
        t_path_split();
        t_protect();
        t_template();
        t_defer();
        report_and_stop();
    end
endmodule
